// ===== core/pri_map.svh
// Register offsets, field positions, reset values and command codes of the priority controller.
`ifndef PRI_MAP_SVH
`define PRI_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PRI_OFF_CTRL      5'h00
`define PRI_OFF_VECTOR    5'h04
`define PRI_OFF_MASK      5'h08
`define PRI_OFF_CMD       5'h0c
`define PRI_OFF_STATUS    5'h10
`define PRI_OFF_POLL      5'h14
`define PRI_OFF_ACK       5'h18

// ****************************************************************
// Control register fields
// ****************************************************************
`define PRI_CTRL_AUTO_EOS 0
`define PRI_CTRL_FULLY    1
`define PRI_CTRL_ROTATE   2
`define PRI_CTRL_SPECIAL  3

// ****************************************************************
// Command word: opcode in bits 6:4, operand in bits 2:0
// ****************************************************************
`define PRI_CMD_NONSPEC   3'h1
`define PRI_CMD_SPEC      3'h2
`define PRI_CMD_ROT_SPEC  3'h3
`define PRI_CMD_SET_BOT   3'h4
`define PRI_CMD_POLL      3'h5
`define PRI_CMD_STAT_SEL  3'h6

// ****************************************************************
// Status select codes and reset values
// ****************************************************************
`define PRI_STAT_PENDING  2'h0
`define PRI_STAT_SERVICE  2'h1
`define PRI_STAT_MASK     2'h2
`define PRI_RST_BOTTOM    3'h7
`define PRI_RST_MASK      8'h00
`define PRI_RST_VECTOR    5'h00

`endif

// ===== core/pri_pkg.sv
// Types shared by the priority controller.
package pri_pkg;

    typedef enum logic [1:0]
    {
        PRI_IDLE = 2'b01,
        PRI_ANS  = 2'b10
    } pri_bus_e;

endpackage

// ===== core/pri_ctrl.sv
// Eight-line priority interrupt controller with an Avalon-MM register slave.
`timescale 1ns/100ps
`include "pri_map.svh"

// How it works
// - Arbitrate, raise one request, supply vector identifier.
// - Interrupt only when above current in-service level.
// - Eight request lines, any may carry subordinate.
// - Reset gives fixed priority, line zero highest.
// - After acknowledge, lower lines blocked, higher pass.
// - End-of-service command clears the in-service level.
// - Fully nested lets same line interrupt again.
// - Auto rotation makes serviced line the lowest.
// - Auto rotation happens at non-specific end-of-service; with auto end-of-service on, at acknowledge.
// - Software names bottom line; next one is highest.
// - Specific rotate end clears line, makes it bottom.
// - Bottom priority settable any time by command.
// - Each line maskable; masked lines never interrupt.
// - Masked in-service line still blocks lower lines.
// - Special mask mode lets lower lines through.
// - Poll read acknowledges and returns pending level.
// - Pending, in-service and mask readable after select.
// - Vector: five software bits, three level bits.
// - Auto end-of-service bit lets hardware clear service on acknowledge reads, not poll reads.
module pri_ctrl
    import pri_pkg::*;
#(
    parameter int LINES = 8
)
(
    input  wire logic              clk_in,
    input  wire logic              resetn_in,
    input  wire logic              ce_in,
    input  wire logic [4:0]        address_in,
    input  wire logic              read_in,
    input  wire logic              write_in,
    input  wire logic [31:0]       writedata_in,
    input  wire logic [LINES-1:0]  req_in,
    output logic      [31:0]       readdata_out,
    output logic                   waitrequest_out,
    output logic                   irq_out
);

    // ****************************************************************
    // Priority functions
    // ****************************************************************
    // Rank 0 is the highest; the line one above the bottom line holds it.
    function automatic logic [2:0] rank_of(input logic [2:0] line, input logic [2:0] bottom);
        rank_of = 3'(line - bottom - 3'h1);
    endfunction

    // Returns {valid, line} of the highest ranked set bit.
    function automatic logic [3:0] best_of(input logic [7:0] vec, input logic [2:0] bottom);
        logic [2:0] line;
        best_of = 4'h0;
        for (int k = 7; k >= 0; k--)
        begin
            line = 3'(bottom + 3'h1 + 3'(k));
            if (vec[line])
                best_of = {1'b1, line};
        end
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    pri_bus_e       state_reg;
    logic [7:0]     pending_reg;
    logic [7:0]     mask_reg;
    logic [7:0]     in_service_reg;
    logic [7:0]     in_service_next;
    logic [2:0]     bottom_reg;
    logic [2:0]     bottom_next;
    logic [3:0]     ctrl_reg;
    logic [4:0]     vector_reg;
    logic [1:0]     stat_sel_reg;
    logic           poll_arm_reg;
    logic           poll_arm_next;
    logic           sel_valid_reg;
    logic [2:0]     sel_line_reg;
    logic [31:0]    rdata;

    wire auto_eos   = ctrl_reg[`PRI_CTRL_AUTO_EOS];
    wire fully      = ctrl_reg[`PRI_CTRL_FULLY];
    wire rotate     = ctrl_reg[`PRI_CTRL_ROTATE];
    wire special    = ctrl_reg[`PRI_CTRL_SPECIAL];

    // ****************************************************************
    // Priority resolution
    // ****************************************************************
    wire [7:0] eligible = pending_reg & ~mask_reg;
    // A masked in-service line keeps blocking unless special mask mode is on.
    wire [7:0] blocking = special ? (in_service_reg & ~mask_reg) : in_service_reg;
    wire [3:0] top_req  = best_of(eligible, bottom_reg);
    wire [3:0] top_svc  = best_of(blocking, bottom_reg);
    wire [3:0] top_isr  = best_of(in_service_reg, bottom_reg);
    wire [2:0] req_rank = rank_of(top_req[2:0], bottom_reg);
    wire [2:0] svc_rank = rank_of(top_svc[2:0], bottom_reg);
    // Fully nested lets the in-service line itself in, so a subordinate can nest.
    wire       allowed  = top_req[3] && (!top_svc[3] || req_rank < svc_rank
                          || (fully && req_rank == svc_rank));

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // An answered transfer completes even if the enable drops, since the master has already seen waitrequest low.
    wire        accept   = (state_reg == PRI_ANS);
    wire        acc_wr   = accept && write_in;
    wire        acc_rd   = accept && read_in;
    wire [2:0]  opcode   = writedata_in[6:4];
    wire [2:0]  operand  = writedata_in[2:0];
    wire        wr_cmd   = acc_wr && address_in == `PRI_OFF_CMD;
    wire        rd_ack   = acc_rd && address_in == `PRI_OFF_ACK;
    wire        rd_poll  = acc_rd && address_in == `PRI_OFF_POLL && poll_arm_reg;
    wire [7:0]  status   = (stat_sel_reg == `PRI_STAT_PENDING) ? pending_reg :
                           (stat_sel_reg == `PRI_STAT_SERVICE) ? in_service_reg : mask_reg;
    wire [7:0]  poll_byt = poll_arm_reg ? {allowed, 4'h0, top_req[2:0]} : 8'h00;
    wire [7:0]  vect_byt = {vector_reg, allowed ? top_req[2:0] : 3'h7};

    always_comb
    begin
        unique case (address_in)
            `PRI_OFF_CTRL:   rdata = {28'h0, ctrl_reg};
            `PRI_OFF_VECTOR: rdata = {24'h0, vector_reg, 3'h0};
            `PRI_OFF_MASK:   rdata = {24'h0, mask_reg};
            `PRI_OFF_STATUS: rdata = {24'h0, status};
            `PRI_OFF_POLL:   rdata = {24'h0, poll_byt};
            `PRI_OFF_ACK:    rdata = {24'h0, vect_byt};
            default:         rdata = 32'h0;
        endcase
    end

    // ****************************************************************
    // In-service, bottom and poll updates
    // ****************************************************************
    // An acknowledge uses the winner captured when the answer was prepared,
    // so the vector returned and the bit set always agree.
    always_comb
    begin
        in_service_next = in_service_reg;
        bottom_next     = bottom_reg;
        poll_arm_next   = poll_arm_reg;
        if ((rd_ack || rd_poll) && sel_valid_reg)
        begin
            if (!auto_eos || rd_poll)
                in_service_next[sel_line_reg] = 1'b1;
            else if (rotate)
                bottom_next = sel_line_reg;
        end
        if (rd_poll)
            poll_arm_next = 1'b0;
        if (wr_cmd)
        begin
            unique case (opcode)
                `PRI_CMD_NONSPEC:
                begin
                    if (top_isr[3])
                    begin
                        in_service_next[top_isr[2:0]] = 1'b0;
                        if (rotate)
                            bottom_next = top_isr[2:0];
                    end
                end
                `PRI_CMD_SPEC:
                    in_service_next[operand] = 1'b0;
                `PRI_CMD_ROT_SPEC:
                begin
                    in_service_next[operand] = 1'b0;
                    bottom_next = operand;
                end
                `PRI_CMD_SET_BOT:
                    bottom_next = operand;
                `PRI_CMD_POLL:
                    poll_arm_next = 1'b1;
                default:
                    poll_arm_next = poll_arm_next;
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_reg       <= PRI_IDLE;
            waitrequest_out <= 1'b1;
            readdata_out    <= 32'h0;
            sel_valid_reg   <= 1'b0;
            sel_line_reg    <= 3'h0;
        end
        else if (ce_in || accept)
        begin
            unique case (state_reg)
                PRI_IDLE:
                begin
                    if (read_in || write_in)
                    begin
                        state_reg       <= PRI_ANS;
                        waitrequest_out <= 1'b0;
                        readdata_out    <= read_in ? rdata : 32'h0;
                        sel_valid_reg   <= allowed;
                        sel_line_reg    <= top_req[2:0];
                    end
                end
                PRI_ANS:
                begin
                    state_reg       <= PRI_IDLE;
                    waitrequest_out <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pending_reg    <= 8'h00;
            in_service_reg <= 8'h00;
            bottom_reg     <= `PRI_RST_BOTTOM;
            poll_arm_reg   <= 1'b0;
            irq_out        <= 1'b0;
        end
        else
        begin
            if (ce_in)
            begin
                pending_reg <= req_in;
                irq_out     <= allowed;
            end
            // Bus side effects follow the answered transfer, not the enable.
            if (ce_in || accept)
            begin
                in_service_reg <= in_service_next;
                bottom_reg     <= bottom_next;
                poll_arm_reg   <= poll_arm_next;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ctrl_reg     <= 4'h0;
            vector_reg   <= `PRI_RST_VECTOR;
            mask_reg     <= `PRI_RST_MASK;
            stat_sel_reg <= `PRI_STAT_PENDING;
        end
        else if (acc_wr)
        begin
            if (address_in == `PRI_OFF_CTRL)
                ctrl_reg <= writedata_in[3:0];
            if (address_in == `PRI_OFF_VECTOR)
                vector_reg <= writedata_in[7:3];
            if (address_in == `PRI_OFF_MASK)
                mask_reg <= writedata_in[7:0];
            if (wr_cmd && opcode == `PRI_CMD_STAT_SEL)
                stat_sel_reg <= operand[1:0];
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_request;
        (read_in || write_in) && waitrequest_out && state_reg == PRI_IDLE && ce_in;
    endsequence

    sequence s_answer;
        !waitrequest_out;
    endsequence

    a_bus_answer_bound: assert property (s_request |=> s_answer)
        else $error("Bus request not answered in one cycle.");

    a_masked_quiet: assert property (ce_in && eligible == 8'h00 |=> !irq_out)
        else $error("Interrupt raised with no unmasked request.");

    a_lower_blocked: assert property (ce_in && top_svc[3] && top_req[3] && req_rank > svc_rank
        |=> !irq_out)
        else $error("Lower request interrupted over in-service level.");

    a_ack_sets_service: assert property (ce_in && rd_ack && sel_valid_reg && !auto_eos
        |=> in_service_reg[$past(sel_line_reg)])
        else $error("Acknowledge did not set the in-service bit.");

    a_spec_eos_clears: assert property (wr_cmd && opcode == `PRI_CMD_SPEC
        |=> !in_service_reg[$past(operand)])
        else $error("Specific end-of-service left bit set.");

    a_rotate_bottom: assert property (wr_cmd && opcode == `PRI_CMD_ROT_SPEC
        |=> bottom_reg == $past(operand) && !in_service_reg[$past(operand)])
        else $error("Specific rotate did not set bottom line.");

    a_auto_rotate_eos: assert property (wr_cmd && opcode == `PRI_CMD_NONSPEC && rotate && top_isr[3]
        |=> bottom_reg == $past(top_isr[2:0]))
        else $error("Automatic rotation missed on end-of-service.");

    a_ack_no_rotate: assert property (ce_in && rd_ack && !auto_eos && !wr_cmd
        |=> bottom_reg == $past(bottom_reg))
        else $error("Priority rotated at acknowledge time.");

    a_vector_low_bits: assert property (!waitrequest_out && read_in && address_in == `PRI_OFF_ACK
        && sel_valid_reg |-> readdata_out[7:0] == {vector_reg, sel_line_reg})
        else $error("Vector identifier does not match winner.");

    a_poll_sets: assert property (ce_in && rd_poll && sel_valid_reg
        |=> in_service_reg[$past(sel_line_reg)] && !poll_arm_reg)
        else $error("Poll read did not acknowledge.");

    a_irq_follows: assert property (ce_in |=> irq_out == $past(allowed))
        else $error("Interrupt output did not follow priority result.");

    a_pending_follows: assert property (ce_in |=> pending_reg == $past(req_in))
        else $error("Pending bits did not follow request lines.");

    a_nonspec_clears: assert property (wr_cmd && opcode == `PRI_CMD_NONSPEC && top_isr[3]
        |=> !in_service_reg[$past(top_isr[2:0])])
        else $error("End-of-service left top in-service bit set.");

    a_set_bottom: assert property (wr_cmd && opcode == `PRI_CMD_SET_BOT |=> bottom_reg == $past(operand))
        else $error("Bottom line command not applied.");

    a_auto_eos_keep: assert property (rd_ack && auto_eos |=> in_service_reg == $past(in_service_reg))
        else $error("Automatic end-of-service left a bit set.");

    a_poll_byte: assert property (!waitrequest_out && read_in && address_in == `PRI_OFF_POLL && poll_arm_reg
        |-> readdata_out[7:0] == {sel_valid_reg, 4'h0, sel_line_reg})
        else $error("Poll byte does not match winner.");

    a_fully_same_line: assert property (ce_in && fully && top_req[3] && top_svc[3] && req_rank <= svc_rank
        |=> irq_out)
        else $error("Fully nested request was blocked.");

endmodule // pri_ctrl

// ===== test/pri_host.sv
// Host processor model that drives the Avalon-MM register port.
`timescale 1ns/100ps
module pri_host
(
    input  wire logic        clk_in,
    input  wire logic [31:0] readdata_in,
    input  wire logic        waitrequest_in,
    output logic      [4:0]  address_out,
    output logic             read_out,
    output logic             write_out,
    output logic      [31:0] writedata_out
);
    // ****************************************************************
    // Bus master
    // ****************************************************************
    initial
    begin
        address_out   = 5'h00;
        read_out      = 1'b0;
        write_out     = 1'b0;
        writedata_out = 32'h0;
    end

    // Released address and data lines show the inverse, so a stale value never looks fresh.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_in);
        address_out   <= a;
        writedata_out <= d;
        write_out     <= wr;
        read_out      <= ~wr;
        @(posedge clk_in);
        while (waitrequest_in !== 1'b0)
            @(posedge clk_in);
        q = readdata_in;
        address_out   <= ~a;
        writedata_out <= ~d;
        write_out     <= 1'b0;
        read_out      <= 1'b0;
    endtask
endmodule // pri_host

// ===== test/priority_interrupt_controller_tb.sv
// Self-checking bench for the priority controller.
`timescale 1ns/100ps
`include "pri_map.svh"
module priority_interrupt_controller_tb;
    logic        clk_in = 1'b0;
    logic        resetn_in;
    logic        ce_in;
    logic [7:0]  req_in;
    logic [4:0]  address_in;
    logic        read_in;
    logic        write_in;
    logic [31:0] writedata_in;
    logic [31:0] readdata_out;
    logic        waitrequest_out;
    logic        irq_out;
    logic [31:0] q;
    logic [7:0]  seed;
    logic [2:0]  w;
    int          n_mismatch;
    int          tests_run;

    always #5 clk_in = ~clk_in;

    pri_ctrl #(.LINES(8)) dut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .address_in(address_in),
        .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in), .req_in(req_in),
        .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .irq_out(irq_out));
    pri_host host (.clk_in(clk_in), .readdata_in(readdata_out), .waitrequest_in(waitrequest_out),
        .address_out(address_in), .read_out(read_in), .write_out(write_in), .writedata_out(writedata_in));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        host.bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        host.bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic cmd(input logic [2:0] op, input logic [2:0] arg);
        wr(`PRI_OFF_CMD, {25'h0, op, 1'b0, arg});
    endtask
    task automatic stat(input logic [1:0] s, input logic [7:0] exp);
        cmd(`PRI_CMD_STAT_SEL, {1'b0, s});
        rd(`PRI_OFF_STATUS, {24'h0, exp});
    endtask
    // Four edges cover the pending flop, the interrupt output flop and any bus side effect.
    task automatic drive(input logic [7:0] v);
        req_in <= v;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic irq(input logic e);
        chk({31'h0, irq_out}, {31'h0, e});
    endtask
    task automatic clean;
        drive(8'h00);
        for (int i = 0; i < 8; i++)
            cmd(`PRI_CMD_SPEC, i[2:0]);
        wr(`PRI_OFF_CTRL, 32'h0);
        wr(`PRI_OFF_MASK, 32'h0);
        cmd(`PRI_CMD_SET_BOT, `PRI_RST_BOTTOM);
    endtask
    function automatic logic [2:0] win(input logic [7:0] v, input logic [2:0] bot);
        logic [2:0] l;
        for (int i = 1; i <= 8; i++)
        begin
            l = bot + 3'(i);
            if (v[l])
                return l;
        end
        return 3'h7;
    endfunction
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task final_report;
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        final_report;
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial
    begin
        resetn_in  = 1'b0;
        ce_in      = 1'b1;
        req_in     = 8'h00;
        seed       = 8'h03;
        n_mismatch = 0;
        tests_run  = 0;
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'b1;
        rd(`PRI_OFF_CTRL, 32'h0);
        rd(`PRI_OFF_MASK, 32'h0);
        wr(5'h1c, 32'hffffffff);
        rd(5'h1c, 32'h0);
        stat(`PRI_STAT_SERVICE, 8'h00);
        wr(`PRI_OFF_VECTOR, 32'haf);
        rd(`PRI_OFF_VECTOR, 32'ha8);
        for (int k = 0; k < 12; k++)
        begin
            seed = lfsr(seed);
            w = win(seed, 3'h7);
            drive(seed);
            irq(1'b1);
            stat(`PRI_STAT_PENDING, seed);
            rd(`PRI_OFF_ACK, {24'h0, 5'h15, w});
            drive(seed);
            irq(1'b0);
            stat(`PRI_STAT_SERVICE, 8'h01 << w);
            if (w != 3'h0)
            begin
                drive(seed | 8'h01);
                irq(1'b1);
                rd(`PRI_OFF_ACK, 32'ha8);
                cmd(`PRI_CMD_NONSPEC, 3'h0);
            end
            cmd(`PRI_CMD_NONSPEC, 3'h0);
            stat(`PRI_STAT_SERVICE, 8'h00);
        end
        wr(`PRI_OFF_MASK, 32'h04);
        drive(8'h04);
        irq(1'b0);
        stat(`PRI_STAT_MASK, 8'h04);
        drive(8'h02);
        rd(`PRI_OFF_ACK, 32'ha9);
        wr(`PRI_OFF_MASK, 32'h06);
        drive(8'h0a);
        irq(1'b0);
        wr(`PRI_OFF_CTRL, 32'h08);
        drive(8'h0a);
        irq(1'b1);
        wr(`PRI_OFF_CTRL, 32'h00);
        drive(8'h0a);
        irq(1'b0);
        cmd(`PRI_CMD_NONSPEC, 3'h0);
        drive(8'h0a);
        irq(1'b1);
        clean;
        wr(`PRI_OFF_CTRL, 32'h04);
        drive(8'h50);
        rd(`PRI_OFF_ACK, 32'hac);
        drive(8'h50);
        irq(1'b0);
        cmd(`PRI_CMD_NONSPEC, 3'h0);
        rd(`PRI_OFF_ACK, 32'hae);
        cmd(`PRI_CMD_NONSPEC, 3'h0);
        rd(`PRI_OFF_ACK, 32'hac);
        clean;
        cmd(`PRI_CMD_SET_BOT, 3'h5);
        drive(8'h41);
        rd(`PRI_OFF_ACK, 32'hae);
        cmd(`PRI_CMD_ROT_SPEC, 3'h6);
        stat(`PRI_STAT_SERVICE, 8'h00);
        rd(`PRI_OFF_ACK, 32'ha8);
        clean;
        drive(8'h30);
        cmd(`PRI_CMD_POLL, 3'h0);
        rd(`PRI_OFF_POLL, 32'h84);
        stat(`PRI_STAT_SERVICE, 8'h10);
        rd(`PRI_OFF_POLL, 32'h0);
        clean;
        wr(`PRI_OFF_CTRL, 32'h02);
        drive(8'h08);
        rd(`PRI_OFF_ACK, 32'hab);
        drive(8'h08);
        irq(1'b1);
        rd(`PRI_OFF_ACK, 32'hab);
        cmd(`PRI_CMD_NONSPEC, 3'h0);
        stat(`PRI_STAT_SERVICE, 8'h00);
        clean;
        wr(`PRI_OFF_CTRL, 32'h01);
        drive(8'h04);
        rd(`PRI_OFF_ACK, 32'haa);
        stat(`PRI_STAT_SERVICE, 8'h00);
        wr(`PRI_OFF_CTRL, 32'h05);
        drive(8'h50);
        rd(`PRI_OFF_ACK, 32'hac);
        rd(`PRI_OFF_ACK, 32'hae);
        rd(`PRI_OFF_ACK, 32'hac);
        clean;
        ce_in <= 1'b0;
        drive(8'h01);
        irq(1'b0);
        ce_in <= 1'b1;
        drive(8'h01);
        irq(1'b1);
        stat(`PRI_STAT_PENDING, 8'h01);
        // The enable drops while the write is answered; the write must still land.
        fork
            wr(`PRI_OFF_MASK, 32'h01);
            begin
                repeat (2) @(posedge clk_in);
                ce_in <= 1'b0;
                repeat (3) @(posedge clk_in);
                ce_in <= 1'b1;
            end
        join
        rd(`PRI_OFF_MASK, 32'h01);
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        irq(1'b0);
        resetn_in <= 1'b1;
        rd(`PRI_OFF_MASK, 32'h0);
        drive(8'h01);
        irq(1'b1);
        final_report;
    end
endmodule // priority_interrupt_controller_tb
